// *** rtl/access_budget_lut.sv ***
// Clock budget table for memory and I/O transactions.
// Pure logic; illegal combinations answer with legal low.
`timescale 1ns/100ps
module access_budget_lut (
  input  wire logic [2:0] kind,
  input  wire logic [2:0] seq,
  input  wire logic [2:0] scale,
  output logic      [5:0] min_clk,
  output logic      [5:0] max_clk,
  output logic            legal
);
  logic [1:0] xi; // Transfer count index
  assign xi = alu_pkg::XFER_IDX[seq];
  always_comb begin
    min_clk = 6'h00;
    max_clk = 6'h00;
    legal   = 1'b0;
    case (kind)
      alu_pkg::K_MEM_RD: begin
        min_clk = alu_pkg::MEM_RD_MIN[xi];
        max_clk = alu_pkg::MEM_RD_MAX[xi];
        legal   = 1'b1;
      end
      alu_pkg::K_MEM_WR: begin
        min_clk = alu_pkg::MEM_WR_MIN[xi];
        max_clk = alu_pkg::MEM_WR_MAX[xi];
        legal   = 1'b1;
      end
      // Internal space is byte wide: single byte only
      alu_pkg::K_INT_RD, alu_pkg::K_INT_WR: begin
        legal   = (seq == 3'h0);
        min_clk = (kind == alu_pkg::K_INT_RD) ? alu_pkg::MEM_RD_MIN[0]
                                              : alu_pkg::MEM_WR_MIN[0];
        max_clk = (kind == alu_pkg::K_INT_RD) ? alu_pkg::MEM_RD_MAX[0]
                                              : alu_pkg::MEM_WR_MAX[0];
      end
      alu_pkg::K_EXT_RD, alu_pkg::K_EXT_WR: begin
        legal = (seq <= alu_pkg::SEQ_W) && (scale <= alu_pkg::SCL_8X);
        if (legal) begin
          min_clk = (kind == alu_pkg::K_EXT_RD) ? alu_pkg::EXT_RD_MIN[scale]
                                                : alu_pkg::EXT_WR_MIN;
          max_clk = (kind == alu_pkg::K_EXT_RD) ? alu_pkg::EXT_RD_MAX[scale]
                                                : alu_pkg::EXT_WR_MAX[scale];
        end
      end
      default: legal = 1'b0;
    endcase
  end
endmodule

// *** rtl/add_flag_unit.sv ***
// Two's complement adder that also forms the flag byte.
// Pure logic; the caller registers sum and flags.
`timescale 1ns/100ps
module add_flag_unit #(
  parameter int W  = 8,
  parameter int HB = 3
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         cin,
  output logic      [W-1:0] sum,
  output logic      [7:0]   flags
);
  logic [W:0]  full;   // Sum with carry out
  logic [HB+1:0] half; // Low part sum for half-carry
  assign full = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
  assign half = {1'b0, a[HB:0]} + {1'b0, b[HB:0]} + {{(HB+1){1'b0}}, cin};
  assign sum  = full[W-1:0];
  // ==========================================================
  // Flag byte; unused bits read zero, subtract always cleared
  always_comb begin
    flags = 8'h00;
    flags[alu_pkg::FLAG_S]  = full[W-1];
    flags[alu_pkg::FLAG_Z]  = (full[W-1:0] == '0);
    flags[alu_pkg::FLAG_H]  = half[HB+1];
    // like signs in, opposite sign out
    flags[alu_pkg::FLAG_PV] = (a[W-1] == b[W-1]) && (full[W-1] != a[W-1]);
    flags[alu_pkg::FLAG_C]  = full[W];
  end
endmodule

// *** rtl/alu_pkg.sv ***
// Constants for the word/byte add datapath: register map, opcodes,
// flag layout, directive table and access clock budgets.
// Assumes a single clock domain; every user names items as alu_pkg::x.
// How it works
// - Word add-with-carry: primary pair plus source plus carry
// - Extended prefix then 01rr1010 picks source pair
// - Word half-carry comes out of bit 11
// - Byte half-carry comes out of bit 3
// - Overflow: like-signed operands, opposite-signed result
// - Carry from top bit; sign, zero; subtract cleared
// - Byte add stores sum in accumulator only
// - Register, immediate, indirect, indexed byte-add encodings
// - Index-half w bit: 0 high, 1 low byte
// - Memory transfer clock budgets per sequence
// - Internal and scaled external I/O clock budgets
// - Directive prefixes pick word/long mode, extra bytes
// - Flag register holds six arithmetic flags
package alu_pkg;
  // ==========================================================
  // Register map (word index on the register port)
  localparam logic [3:0] REG_ACC    = 4'h0; // Accumulator
  localparam logic [3:0] REG_CNT    = 4'h1; // Counter pair
  localparam logic [3:0] REG_SEC    = 4'h2; // Second pair
  localparam logic [3:0] REG_PRI    = 4'h3; // Primary pair
  localparam logic [3:0] REG_SP     = 4'h4; // Stack pointer
  localparam logic [3:0] REG_IDX1   = 4'h5; // First index register
  localparam logic [3:0] REG_IDX2   = 4'h6; // Second index register
  localparam logic [3:0] REG_FLAGS  = 4'h7; // Flag register
  localparam logic [3:0] REG_MEMOP  = 4'h8; // Memory operand byte
  localparam logic [3:0] REG_MODE   = 4'h9; // Decoder state, read only
  localparam logic [3:0] REG_BUDSEL = 4'ha; // Budget select
  localparam logic [3:0] REG_BUDRES = 4'hb; // Budget result, read only
  // ==========================================================
  // Flag bit positions
  localparam int FLAG_C  = 0;
  localparam int FLAG_N  = 1;
  localparam int FLAG_PV = 2;
  localparam int FLAG_H  = 4;
  localparam int FLAG_Z  = 6;
  localparam int FLAG_S  = 7;
  localparam int HALF_W  = 11; // Word half-carry bit
  localparam int HALF_B  = 3;  // Byte half-carry bit
  // ==========================================================
  // Opcodes, as exact bytes and value and mask pairs
  localparam logic [7:0] OP_EXT   = 8'hed;
  localparam logic [7:0] ADC_MASK = 8'hcf;
  localparam logic [7:0] ADC_VAL  = 8'h4a;
  localparam logic [7:0] ADDR_MSK = 8'hf8;
  localparam logic [7:0] ADDR_VAL = 8'h80;
  localparam logic [7:0] OP_IMM   = 8'hc6;
  localparam logic [7:0] OP_IND   = 8'h86;
  localparam logic [7:0] IDX_MASK = 8'hdf;
  localparam logic [7:0] IDX_VAL  = 8'hdd;
  localparam logic [7:0] HLF_MASK = 8'hfe;
  localparam logic [7:0] HLF_VAL  = 8'h84;
  localparam logic [7:0] DIR_MASK = 8'hfc;
  localparam logic [7:0] DIR_VAL  = 8'hc0;
  // ==========================================================
  // Directive combinations: {word, long, extra bytes[1:0]}
  localparam logic [3:0] DIR_TABLE [8] = '{4'h8, 4'h9, 4'ha, 4'h1,
                                           4'h4, 4'h5, 4'h6, 4'h2};
  // ==========================================================
  // Access kinds and clock budgets
  localparam logic [2:0] K_MEM_RD = 3'h0;
  localparam logic [2:0] K_MEM_WR = 3'h1;
  localparam logic [2:0] K_INT_RD = 3'h2;
  localparam logic [2:0] K_INT_WR = 3'h3;
  localparam logic [2:0] K_EXT_RD = 3'h4;
  localparam logic [2:0] K_EXT_WR = 3'h5;
  localparam logic [2:0] SEQ_W    = 3'h1; // Last single-transfer code
  localparam logic [2:0] SCL_8X   = 3'h4; // Last legal scale code
  localparam logic [5:0] MEM_RD_MIN [4] = '{6'h03, 6'h05, 6'h07, 6'h09};
  localparam logic [5:0] MEM_RD_MAX [4] = '{6'h04, 6'h06, 6'h08, 6'h0a};
  localparam logic [5:0] MEM_WR_MIN [4] = '{6'h00, 6'h02, 6'h04, 6'h06};
  localparam logic [5:0] MEM_WR_MAX [4] = '{6'h01, 6'h03, 6'h05, 6'h07};
  localparam logic [1:0] XFER_IDX [8] = '{2'h0, 2'h0, 2'h1, 2'h1,
                                          2'h2, 2'h2, 2'h2, 2'h3};
  localparam logic [5:0] EXT_RD_MIN [5] = '{6'h04, 6'h09, 6'h11, 6'h19, 6'h21};
  localparam logic [5:0] EXT_RD_MAX [5] = '{6'h05, 6'h0b, 6'h15, 6'h1f, 6'h29};
  localparam logic [5:0] EXT_WR_MAX [5] = '{6'h02, 6'h03, 6'h05, 6'h07, 6'h09};
  localparam logic [5:0] EXT_WR_MIN = 6'h01;
endpackage

// *** rtl/word_byte_add_alu_flags.sv ***
// Adder datapath: word add-with-carry into the primary pair and byte
// add into the accumulator, opcode decode, directive prefixes and a
// readable access clock budget table.
// Assumes opcode bytes and register port are in the ref_clk domain.
`timescale 1ns/100ps
module word_byte_add_alu_flags (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [7:0]  op_byte,
  input  wire logic        op_valid,
  output logic             op_done,
  output logic             word_mode,
  output logic             long_mode,
  output logic      [7:0]  flags
);
  // ==========================================================
  // Decoder states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, // Waiting for first opcode byte
    ST_EXT  = 5'h02, // Extended prefix seen
    ST_IDX  = 5'h04, // Index prefix seen
    ST_DISP = 5'h08, // Waiting for displacement
    ST_IMM  = 5'h10  // Waiting for immediate bytes
  } dec_state_e;

  dec_state_e  state_reg;     // Current decoder state
  dec_state_e  state_next;    // Next decoder state
  logic [7:0]  acc_reg;       // Accumulator
  logic [15:0] cnt_reg;       // Counter pair
  logic [15:0] sec_reg;       // Second pair
  logic [15:0] pri_reg;       // Primary pair
  logic [15:0] sp_reg;        // Stack pointer
  logic [15:0] idx1_reg;      // First index register
  logic [15:0] idx2_reg;      // Second index register
  logic [7:0]  flag_reg;      // Flag register
  logic [7:0]  memop_reg;     // Byte fetched for indirect forms
  logic        alt_idx_reg;   // Index prefix picked second index
  logic [3:0]  dir_reg;       // Armed directive {word,long,extra}
  logic [1:0]  imm_left_reg;  // Immediate bytes still due
  logic        imm_first_reg; // Next immediate byte is the operand
  logic [7:0]  imm_hold_reg;  // Operand byte held across extras
  logic [8:0]  bud_sel_reg;   // {kind, seq, scale}
  logic [12:0] bud_res_reg;   // {legal, max, min}
  logic [15:0] rdata_reg;     // Read data, one cycle after strobe
  logic        done_reg;      // One-cycle completion pulse
  logic        word_reg;      // Word mode output flop
  logic        long_reg;      // Long mode output flop

  // ==========================================================
  // Helpers
  // Masked opcode compare, used by every decode term except the exact-byte ones
  function automatic logic op_match(input logic [7:0] b,
                                    input logic [7:0] m,
                                    input logic [7:0] v);
    return (b & m) == v;
  endfunction

  // Byte register field: B C D E H L (mem) A; passed in so the assign sees changes
  function automatic logic [7:0] reg8(input logic [2:0] r, input logic [63:0] rf);
    case (r)
      3'h0:    return rf[63:56];
      3'h1:    return rf[55:48];
      3'h2:    return rf[47:40];
      3'h3:    return rf[39:32];
      3'h4:    return rf[31:24];
      3'h5:    return rf[23:16];
      3'h6:    return rf[15:8];
      default: return rf[7:0];
    endcase
  endfunction

  // Register port read selection; unmapped addresses read zero
  function automatic logic [15:0] rd_word(input logic [3:0] a);
    case (a)
      alu_pkg::REG_ACC:    return {8'h00, acc_reg};
      alu_pkg::REG_CNT:    return cnt_reg;
      alu_pkg::REG_SEC:    return sec_reg;
      alu_pkg::REG_PRI:    return pri_reg;
      alu_pkg::REG_SP:     return sp_reg;
      alu_pkg::REG_IDX1:   return idx1_reg;
      alu_pkg::REG_IDX2:   return idx2_reg;
      alu_pkg::REG_FLAGS:  return {8'h00, flag_reg};
      alu_pkg::REG_MEMOP:  return {8'h00, memop_reg};
      alu_pkg::REG_MODE:   return {11'h000, state_reg};
      alu_pkg::REG_BUDSEL: return {7'h00, bud_sel_reg};
      alu_pkg::REG_BUDRES: return {3'h0, bud_res_reg};
      default:             return 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // Opcode decode
  logic st_idle, st_ext, st_idx, st_disp, st_imm;
  logic is_add_r, is_imm, is_adc, is_half, is_ind, is_dir, is_pfx;
  assign st_idle = (state_reg == ST_IDLE);
  assign st_ext  = (state_reg == ST_EXT);
  assign st_idx  = (state_reg == ST_IDX);
  assign st_disp = (state_reg == ST_DISP);
  assign st_imm  = (state_reg == ST_IMM);
  assign is_add_r = op_match(op_byte, alu_pkg::ADDR_MSK, alu_pkg::ADDR_VAL);
  assign is_imm   = (op_byte == alu_pkg::OP_IMM);
  assign is_ind   = (op_byte == alu_pkg::OP_IND);
  assign is_pfx   = op_match(op_byte, alu_pkg::IDX_MASK, alu_pkg::IDX_VAL);
  assign is_half  = op_match(op_byte, alu_pkg::HLF_MASK, alu_pkg::HLF_VAL);
  assign is_dir   = op_match(op_byte, alu_pkg::DIR_MASK, alu_pkg::DIR_VAL);
  assign is_adc   = op_match(op_byte, alu_pkg::ADC_MASK, alu_pkg::ADC_VAL);

  logic add8_go;  // Byte add completes this cycle
  logic add16_go; // Word add completes this cycle
  assign add8_go  = op_valid && ((st_idle && is_add_r) || (st_idx && is_half)
                    || st_disp || (st_imm && imm_left_reg == 2'h0));
  assign add16_go = op_valid && st_ext && is_adc;

  // ==========================================================
  // Operand selection
  logic [15:0] idx_sel;  // Index register named by the prefix
  logic [7:0]  half_sel; // Chosen half of that register
  logic [7:0]  b_src;    // Byte add source
  logic [15:0] w_src;    // Word add source pair
  logic [3:0]  dir_code; // Directive combination looked up
  assign idx_sel = alt_idx_reg ? idx2_reg : idx1_reg;
  // w bit picks high or low half
  assign half_sel = op_byte[0] ? idx_sel[7:0] : idx_sel[15:8];
  assign b_src = st_idx  ? half_sel :
                 st_disp ? memop_reg :
                 st_imm  ? (imm_first_reg ? op_byte : imm_hold_reg) :
                 reg8(op_byte[2:0], {cnt_reg, sec_reg, pri_reg, memop_reg, acc_reg});
  // rr field picks the source pair
  assign w_src = (op_byte[5:4] == 2'h0) ? cnt_reg :
                 (op_byte[5:4] == 2'h1) ? sec_reg :
                 (op_byte[5:4] == 2'h2) ? pri_reg : sp_reg;
  assign dir_code = alu_pkg::DIR_TABLE[{alt_idx_reg, op_byte[1:0]}];

  // ==========================================================
  // Adders and budget table
  logic [7:0]  sum8, flags8;
  logic [15:0] sum16;
  logic [7:0]  flags16;
  logic [5:0]  bud_min, bud_max;
  logic        bud_legal;

  // byte adder, half-carry from bit 3
  add_flag_unit #(.W(8), .HB(alu_pkg::HALF_B)) u_add8 (
    .a     (acc_reg),
    .b     (b_src),
    .cin   (1'b0),
    .sum   (sum8),
    .flags (flags8)
  );
  // word adder, half-carry from bit 11
  add_flag_unit #(.W(16), .HB(alu_pkg::HALF_W)) u_add16 (
    .a     (pri_reg),
    .b     (w_src),
    .cin   (flag_reg[alu_pkg::FLAG_C]),
    .sum   (sum16),
    .flags (flags16)
  );
  access_budget_lut u_budget (
    .kind    (bud_sel_reg[8:6]),
    .seq     (bud_sel_reg[5:3]),
    .scale   (bud_sel_reg[2:0]),
    .min_clk (bud_min),
    .max_clk (bud_max),
    .legal   (bud_legal)
  );

  // ==========================================================
  // Decoder next state; unknown bytes fall back to idle
  always_comb begin
    state_next = state_reg;
    if (op_valid) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (op_byte == alu_pkg::OP_EXT) begin
            state_next = ST_EXT;
          end else if (is_pfx) begin
            state_next = ST_IDX;
          end else if (is_imm) begin
            state_next = ST_IMM;
          end
        end
        ST_IDX: begin
          state_next = is_ind ? ST_DISP : ST_IDLE;
        end
        ST_IMM: begin
          state_next = (imm_left_reg == 2'h0) ? ST_IDLE : ST_IMM;
        end
        ST_EXT, ST_DISP: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Decoder sequencing and immediate tracking
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      alt_idx_reg   <= 1'b0;
      imm_left_reg  <= 2'h0;
      imm_first_reg <= 1'b0;
      imm_hold_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (op_valid && st_idle) begin
        alt_idx_reg   <= op_byte[5];
        imm_left_reg  <= dir_reg[1:0];
        imm_first_reg <= 1'b1;
      end else if (op_valid && st_imm) begin
        // Extra directive bytes are consumed; only the first is used
        if (imm_first_reg) begin
          imm_hold_reg <= op_byte;
        end
        imm_first_reg <= 1'b0;
        if (imm_left_reg != 2'h0) begin
          imm_left_reg <= imm_left_reg - 2'h1;
        end
      end
    end
  end

  // ==========================================================
  // Directive: armed by the prefix, spent by the next instruction
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dir_reg <= 4'h0;
    end else if (op_valid && st_idx && is_dir) begin
      // arm word/long mode and extra bytes
      dir_reg <= dir_code;
    end else if (add8_go || add16_go) begin
      dir_reg <= 4'h0;
    end
  end

  // ==========================================================
  // Register file; an add in the same cycle beats a port write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_reg   <= 8'h00;
      cnt_reg   <= 16'h0000;
      sec_reg   <= 16'h0000;
      pri_reg   <= 16'h0000;
      sp_reg    <= 16'h0000;
      idx1_reg  <= 16'h0000;
      idx2_reg  <= 16'h0000;
      flag_reg  <= 8'h00;
      memop_reg <= 8'h00;
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          alu_pkg::REG_ACC:   acc_reg   <= reg_wdata[7:0];
          alu_pkg::REG_CNT:   cnt_reg   <= reg_wdata;
          alu_pkg::REG_SEC:   sec_reg   <= reg_wdata;
          alu_pkg::REG_PRI:   pri_reg   <= reg_wdata;
          alu_pkg::REG_SP:    sp_reg    <= reg_wdata;
          alu_pkg::REG_IDX1:  idx1_reg  <= reg_wdata;
          alu_pkg::REG_IDX2:  idx2_reg  <= reg_wdata;
          alu_pkg::REG_FLAGS: flag_reg  <= reg_wdata[7:0];
          alu_pkg::REG_MEMOP: memop_reg <= reg_wdata[7:0];
          default: ;
        endcase
      end
      if (add8_go) begin
        acc_reg  <= sum8;
        flag_reg <= flags8;
      end
      if (add16_go) begin
        pri_reg  <= sum16;
        flag_reg <= flags16;
      end
    end
  end

  // ==========================================================
  // Budget select, result, read data and output flops
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bud_sel_reg <= 9'h000;
      bud_res_reg <= 13'h0000;
      rdata_reg   <= 16'h0000;
      done_reg    <= 1'b0;
      word_reg    <= 1'b0;
      long_reg    <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == alu_pkg::REG_BUDSEL) begin
        bud_sel_reg <= reg_wdata[8:0];
      end
      bud_res_reg <= {bud_legal, bud_max, bud_min};
      rdata_reg   <= reg_rd ? rd_word(reg_addr) : 16'h0000;
      done_reg    <= add8_go || add16_go;
      word_reg    <= dir_reg[3];
      long_reg    <= dir_reg[2];
    end
  end

  assign reg_rdata = rdata_reg;
  assign op_done   = done_reg;
  assign word_mode = word_reg;
  assign long_mode = long_reg;
  assign flags     = flag_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  logic [16:0] chk16; // Independent word sum
  logic [12:0] chk_h16;
  logic [8:0]  chk8;  // Independent byte sum
  logic [4:0]  chk_h8;
  assign chk16   = {1'b0, pri_reg} + {1'b0, w_src}
                   + {16'h0000, flag_reg[alu_pkg::FLAG_C]};
  assign chk_h16 = {1'b0, pri_reg[11:0]} + {1'b0, w_src[11:0]}
                   + {12'h000, flag_reg[alu_pkg::FLAG_C]};
  assign chk8    = {1'b0, acc_reg} + {1'b0, b_src};
  assign chk_h8  = {1'b0, acc_reg[3:0]} + {1'b0, b_src[3:0]};

  sequence s_ext_pfx;
    op_valid && st_idle && op_byte == alu_pkg::OP_EXT;
  endsequence
  sequence s_adc_op;
    op_valid && is_adc;
  endsequence

  AST_ADC_SUM: assert property (add16_go |=> pri_reg == $past(chk16[15:0]))
    else $error("word add result wrong");
  AST_ADC_DECODE: assert property (s_ext_pfx ##1 s_adc_op |=> op_done)
    else $error("extended add not completed");
  AST_WORD_HALF: assert property (
    add16_go |=> flag_reg[alu_pkg::FLAG_H] == $past(chk_h16[12]))
    else $error("word half-carry wrong");
  AST_BYTE_HALF: assert property (
    add8_go |=> flag_reg[alu_pkg::FLAG_H] == $past(chk_h8[4]))
    else $error("byte half-carry wrong");
  AST_OVERFLOW: assert property (add8_go |=> flag_reg[alu_pkg::FLAG_PV] ==
    $past(acc_reg[7] == b_src[7] && chk8[7] != acc_reg[7]))
    else $error("overflow flag wrong");
  AST_CARRY_N: assert property (add8_go |=>
    flag_reg[alu_pkg::FLAG_C] == $past(chk8[8]) && !flag_reg[alu_pkg::FLAG_N]
    && flag_reg[alu_pkg::FLAG_Z] == (acc_reg == 8'h00))
    else $error("carry, subtract or zero flag wrong");
  AST_ACC_ADD: assert property (add8_go && !reg_wr |=>
    acc_reg == $past(chk8[7:0]) && $stable(memop_reg))
    else $error("accumulator sum wrong");
  AST_HALF_SEL: assert property (op_valid && st_idx && is_half |->
    b_src == 8'((alt_idx_reg ? idx2_reg : idx1_reg) >> (op_byte[0] ? 0 : 8)))
    else $error("index half selection wrong");
  AST_DIR_MODE: assert property (op_valid && st_idx && is_dir |=> ##1
    word_mode == $past(dir_code[3], 2) && long_mode == $past(dir_code[2], 2))
    else $error("directive mode not shown");
  AST_MEM_BUDGET: assert property (!$past(sys_rst) &&
    $past(bud_sel_reg[8:6]) == alu_pkg::K_MEM_RD |-> bud_res_reg[11:6] == bud_res_reg[5:0] + 6'h01)
    else $error("memory read budget span wrong");
  AST_FLAGS_HOLD: assert property (!add8_go && !add16_go && !reg_wr |=>
    $stable(flag_reg))
    else $error("flags changed without an add");
endmodule

// *** verif/testbench.sv ***
// Bench for the add datapath: random and corner adds, directives, budgets.
// Assumes register reads answer exactly one cycle after the strobe.
`timescale 1ns/100ps
module testbench;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, op_valid, op_done, word_mode, long_mode, c, dn;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, a, b, d;
  logic [7:0]  op_byte, flags;
  logic [1:0]  rr;
  logic [23:0] e;
  int          bad_count, checked, cyc, seed, i;
  word_byte_add_alu_flags i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_byte(op_byte), .op_valid(op_valid), .op_done(op_done), .word_mode(word_mode),
    .long_mode(long_mode), .flags(flags));
  // ==========================================================
  // Clock and hang guard; the run needs under a thousand cycles
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // Expected {flags, sum}; byte adds run in the top byte so bit 11 gives the half carry
  function automatic logic [23:0] addf(input logic [15:0] x, input logic [15:0] y,
                                       input logic ci, input logic w);
    logic [16:0] s;
    logic [12:0] t;
    if (!w) begin
      x = x << 8;
      y = y << 8;
    end
    s = {1'b0, x} + {1'b0, y} + {16'h0, ci};
    t = {1'b0, x[11:0]} + {1'b0, y[11:0]} + {12'h0, ci};
    return {s[15], s[15:0] == 16'h0, 1'b0, t[12], 1'b0,
            (x[15] == y[15]) && (s[15] != x[15]), 1'b0, s[16],
            w ? s[15:0] : {8'h0, s[15:8]}};
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] v);
    reg_addr  <= ad;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    // One idle edge, so a second write never drives the strobe twice in one step
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [3:0] ad, output logic [15:0] v);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask
  // Two opcode bytes back to back, then the done pulse is sampled
  task automatic send(input logic [7:0] b0, input logic [7:0] b1);
    op_byte  <= b0;
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_byte  <= b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    @(negedge ref_clk);
    dn = op_done;
    @(posedge ref_clk);
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {seed, bad_count, checked, cyc} = {32'd89, 96'd0};
    {sys_rst, reg_wr, reg_rd, op_valid, reg_addr, reg_wdata, op_byte} = {1'b1, 31'h0};
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 40; i++) begin
      a  = 16'($random(seed));
      b  = 16'($random(seed));
      c  = 1'($random(seed));
      rr = 2'($random(seed));
      // First passes are corners: zero with carry, and sign overflow
      if (i < 2) {a, b, c, rr} = (i == 0) ? {16'hffff, 16'h0, 1'b1, 2'h0}
                                          : {16'h8080, 16'h8080, 1'b0, 2'h1};
      wr(alu_pkg::REG_ACC, {8'h0, a[7:0]});
      send(alu_pkg::OP_IMM, b[7:0]);
      e = addf(a, b, 1'b0, 1'b0);
      cmp({15'h0, dn}, 16'h1);
      cmp({8'h0, flags}, {8'h0, e[23:16]});
      rd(alu_pkg::REG_ACC, d);
      cmp(d, e[15:0]);
      if (rr == 2'h2) a = b;
      wr(alu_pkg::REG_FLAGS, {15'h0, c});
      wr(alu_pkg::REG_PRI, a);
      wr(4'(alu_pkg::REG_CNT + rr), b);
      send(alu_pkg::OP_EXT, {2'b01, rr, 4'ha});
      e = addf(a, b, c, 1'b1);
      cmp({15'h0, dn}, 16'h1);
      cmp({8'h0, flags}, {8'h0, e[23:16]});
      rd(alu_pkg::REG_PRI, d);
      cmp(d, e[15:0]);
    end
    // Index-half high and low, then register form B, all into the accumulator
    wr(alu_pkg::REG_IDX2, 16'h7f01);
    wr(alu_pkg::REG_CNT, 16'hc300);
    for (i = 0; i < 3; i++) begin
      wr(alu_pkg::REG_ACC, 16'h0041);
      send((i < 2) ? 8'hfd : 8'h80, (i < 2) ? {7'h42, i[0]} : 8'h00);
      e = addf(16'h0041, (i == 0) ? 16'h007f : (i == 1) ? 16'h0001 : 16'h00c3, 1'b0, 1'b0);
      cmp({8'h0, flags}, {8'h0, e[23:16]});
      rd(alu_pkg::REG_ACC, d);
      cmp(d, e[15:0]);
    end
    // Word and long-word directives arm the mode; the next add clears it
    for (i = 0; i < 2; i++) begin
      send(i ? 8'hfd : 8'hdd, 8'hc0);
      repeat (2) @(posedge ref_clk);
      cmp({14'h0, word_mode, long_mode}, i ? 16'h1 : 16'h2);
      send(alu_pkg::OP_IMM, 8'h00);
      // Mode flop follows the cleared directive one edge after the add
      @(posedge ref_clk);
      cmp({14'h0, word_mode, long_mode}, 16'h0);
    end
    wr(alu_pkg::REG_BUDSEL, 16'h0038);
    @(posedge ref_clk);
    rd(alu_pkg::REG_BUDRES, d);
    cmp(d, 16'h1289);
    wr(alu_pkg::REG_BUDSEL, 16'h0104);
    @(posedge ref_clk);
    rd(alu_pkg::REG_BUDRES, d);
    cmp(d, 16'h1a61);
    wr(alu_pkg::REG_MODE, 16'hffff);
    rd(alu_pkg::REG_MODE, d);
    cmp(d, 16'h0001);
    rd(4'hc, d);
    cmp(d, 16'h0000);
    report_and_stop();
  end
endmodule
